// ==== inc/power_save_clock_regs.svh ====
// register offsets, field positions, reset values and counts of the
// power save clock mode controller; included by the module only
`ifndef POWER_SAVE_CLOCK_REGS_SVH
`define POWER_SAVE_CLOCK_REGS_SVH

`define PSM_OFF_CTRL 12'h000
`define PSM_OFF_STATUS 12'h004
`define PSM_OFF_POWER 12'h008

`define PSM_CTRL_RESET 8'h40
`define PSM_BIT_SLOW_ON 7
`define PSM_BIT_FAST_ON 6
`define PSM_BIT_IDLE_SEL 5
`define PSM_BIT_CORE_SEL 4
`define PSM_BIT_RSVD 3

`define PSM_STAT_PEND 4
`define PSM_PWR_HALT 0
`define PSM_PWR_IDLE 1

`define PSM_INSTR_DIV 5
`define PSM_TIMER_W 17
`define PSM_TAP_BASE 12
`define PSM_TAP_MAX 4
`define PSM_PRESET_HI 12'h00F
`define PSM_SWITCH_EDGES 2

`endif

// ==== inc/power_save_clock_pkg.sv ====
// types shared by the power save clock mode controller
// assumes nothing of its surroundings
package power_save_clock_pkg;

    typedef enum logic [1:0] {
        MODE_HIGH = 2'b00,
        MODE_DUAL = 2'b01,
        MODE_LOW = 2'b10
    } mode_type;

    typedef enum logic [1:0] {
        CLK_FAST = 2'b00,
        CLK_TO_SLOW = 2'b01,
        CLK_SLOW = 2'b10,
        CLK_TO_FAST = 2'b11
    } clk_state_type;

    typedef enum logic [1:0] {
        PS_RUN = 2'b00,
        PS_HALT = 2'b01,
        PS_IDLE = 2'b10
    } power_state_type;

endpackage : power_save_clock_pkg

// ==== logic/power_save_clock_mode_control.sv ====
// power save mode control register, mode decode, illegal mode reset,
// idle timer with window select, halt/idle control, core clock gating
// assumes an ahb-lite master on hclk (fast oscillator) and a slow
// oscillator and wake-up level arriving asynchronously on pins
`timescale 1ns/1ps
`include "power_save_clock_regs.svh"

// Summary of operation
// - any reset loads the control register with 40 hex.
// - bit 7 switches the slow oscillator on or off.
// - bit 6 switches the fast oscillator on or off.
// - bit 5 picks idle timer clock: 0 fast, 1 slow.
// - bit 4 picks core clock: 0 fast, 1 slow.
// - select pair 00 high speed, 10 dual clock, 11 low speed.
// - pair 01 is invalid; no legal nibble holds it, so writing it raises internal reset.
// - only five upper nibble patterns are legal.
// - any other upper nibble raises an internal reset.
// - that reset presets idle timer to 00Fx, lasting 241-256 instruction cycles.
// - bits 2-0 carry the idle interval select to the idle timer.
// - three operating modes, each with halt and idle.
// - halt stops core and peripherals; option input permits halt.
// - idle keeps oscillator and idle timer running.
// - power save modes keep all state except the idle timer.
// - interval field picks 4k to 64k window; reset picks 4k.
module power_save_clock_mode_control
    import power_save_clock_pkg::*;
#(
    parameter int INSTR_DIV = `PSM_INSTR_DIV,
    parameter int SWITCH_EDGES = `PSM_SWITCH_EDGES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic slow_osc_clock,
    input wire logic wakeup_pin,
    input wire logic halt_option_enable,
    output logic slow_osc_on,
    output logic fast_osc_on,
    output logic idle_timer_clock_sel,
    output logic core_clock_sel,
    output logic [2:0] idle_interval_sel,
    output logic core_fast_gate,
    output logic core_slow_gate,
    output logic core_run,
    output logic periph_run,
    output logic internal_reset_n,
    output logic idle_window_tick
);

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic slow_s1_q;
    logic slow_s2_q;
    logic slow_s3_q;
    logic wake_s1_q;
    logic wake_s2_q;
    logic [7:0] div_q;
    logic fast_tick;
    logic slow_edge;
    logic timer_tick;
    logic [`PSM_TIMER_W-1:0] timer_q;
    logic [`PSM_TIMER_W-1:0] tap_mask;
    logic window_hit;
    logic ireset_q;
    logic ireset_start;
    logic pend_q;
    logic tick_q;
    mode_type mode;
    clk_state_type clk_q;
    logic [1:0] edge_cnt_q;
    power_state_type ps_q;
    logic halt_req;
    logic idle_req;
    logic pend_clr;
    logic ctrl_wr;
    logic addr_ok;

    // ---------------- ahb-lite slave ----------------
    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr;
            end
        end
    end

    // read data is captured in the address phase and stands in the
    // data phase; unmapped words read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            if (haddr[11:2] == 10'(`PSM_OFF_CTRL >> 2)) begin
                rdata_q <= {24'h000000, ctrl_q};
            end else if (haddr[11:2] == 10'(`PSM_OFF_STATUS >> 2)) begin
                rdata_q <= {27'h0, pend_q, ps_q, mode};
            end else if (haddr[11:2] == 10'(`PSM_OFF_POWER >> 2)) begin
                rdata_q <= {30'h0, ps_q == PS_IDLE,
                            ps_q == PS_HALT};
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    assign ctrl_wr = wr_pend_q && !ireset_q &&
                     wr_addr_q[11:2] == 10'(`PSM_OFF_CTRL >> 2);
    assign pend_clr = wr_pend_q &&
                      wr_addr_q[11:2] == 10'(`PSM_OFF_STATUS >> 2) &&
                      hwdata[`PSM_STAT_PEND];
    assign halt_req = wr_pend_q && !ireset_q &&
                      wr_addr_q[11:2] == 10'(`PSM_OFF_POWER >> 2) &&
                      hwdata[`PSM_PWR_HALT];
    assign idle_req = wr_pend_q && !ireset_q &&
                      wr_addr_q[11:2] == 10'(`PSM_OFF_POWER >> 2) &&
                      hwdata[`PSM_PWR_IDLE];

    // ---------------- control register ----------------
    // reserved bit is stored as zero whatever is written
    assign ctrl_d = {hwdata[7:4], 1'b0, hwdata[2:0]};

    function automatic logic nibble_legal(input logic [3:0] n);
        // legal: 0100, 1100, 1110, 1111, 1011
        nibble_legal = (n == 4'h4) || (n == 4'hC) || (n == 4'hE) ||
                       (n == 4'hF) || (n == 4'hB);
    endfunction : nibble_legal

    // illegal nibble written: start internal reset
    assign ireset_start = ctrl_wr && !nibble_legal(ctrl_d[7:4]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `PSM_CTRL_RESET;
        end else if (ireset_start) begin
            ctrl_q <= `PSM_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= ctrl_d;
        end
    end

    assign slow_osc_on = ctrl_q[`PSM_BIT_SLOW_ON];
    assign fast_osc_on = ctrl_q[`PSM_BIT_FAST_ON];
    assign idle_timer_clock_sel = ctrl_q[`PSM_BIT_IDLE_SEL];
    assign core_clock_sel = ctrl_q[`PSM_BIT_CORE_SEL];
    assign idle_interval_sel = ctrl_q[2:0];

    // mode decode; pair 01 is treated as low speed
    always_comb begin
        case ({ctrl_q[`PSM_BIT_IDLE_SEL], ctrl_q[`PSM_BIT_CORE_SEL]})
            2'b00: mode = MODE_HIGH;
            2'b10: mode = MODE_DUAL;
            default: mode = MODE_LOW;
        endcase
    end

    // ---------------- synchronisers and ticks ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_s1_q <= 1'b0;
            slow_s2_q <= 1'b0;
            slow_s3_q <= 1'b0;
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end else begin
            slow_s1_q <= slow_osc_clock;
            slow_s2_q <= slow_s1_q;
            slow_s3_q <= slow_s2_q;
            wake_s1_q <= wakeup_pin;
            wake_s2_q <= wake_s1_q;
        end
    end

    assign slow_edge = slow_s2_q && !slow_s3_q && slow_osc_on;

    // instruction cycle tick from the fast oscillator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 8'h00;
        end else if (div_q == 8'(INSTR_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    assign fast_tick = (div_q == 8'(INSTR_DIV - 1)) && fast_osc_on;

    // internal reset always counts instruction cycles; halt freezes
    // the timer, idle keeps it running
    assign timer_tick = ireset_q ? fast_tick :
                        (ps_q == PS_HALT) ? 1'b0 :
                        idle_timer_clock_sel ? slow_edge : fast_tick;

    // ---------------- idle timer ----------------
    // window taps 4k..64k; codes above 64k use the 64k tap
    always_comb begin
        tap_mask = '0;
        for (int i = 0; i < `PSM_TIMER_W; i++) begin
            if (i < `PSM_TAP_BASE + ((idle_interval_sel > 3'(`PSM_TAP_MAX))
                ? `PSM_TAP_MAX : int'(idle_interval_sel))) begin
                tap_mask[i] = 1'b1;
            end
        end
    end

    // selected bit toggles on the decrement from an all-zero low part
    assign window_hit = timer_tick && ((timer_q & tap_mask) == '0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_q <= '0;
        end else if (ireset_start) begin
            // preset to 00Fx, keeping the running low nibble
            timer_q <= {1'b0, `PSM_PRESET_HI, timer_q[3:0]};
        end else if (timer_tick) begin
            timer_q <= timer_q - 1'b1;
        end
    end

    // internal reset lasts until the preset timer underflows
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ireset_q <= 1'b0;
        end else if (ireset_start) begin
            ireset_q <= 1'b1;
        end else if (ireset_q && fast_tick && timer_q == '0) begin
            ireset_q <= 1'b0;
        end
    end

    assign internal_reset_n = !ireset_q;

    // window pending flag; a new hit wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= window_hit && !ireset_q;
            if (window_hit && !ireset_q) begin
                pend_q <= 1'b1;
            end else if (pend_clr) begin
                pend_q <= 1'b0;
            end
        end
    end

    assign idle_window_tick = tick_q;

    // ---------------- glitch-free core clock switch ----------------
    // break before make outside internal reset, which goes straight to fast: the old gate closes, then the new one opens
    // only after a number of synchronised slow edges, or of hclk cycles when going back to fast with the slow oscillator off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_q <= CLK_FAST;
            edge_cnt_q <= 2'b00;
        end else if (ireset_q) begin
            clk_q <= CLK_FAST;
            edge_cnt_q <= 2'b00;
        end else begin
            case (clk_q)
                CLK_FAST: begin
                    edge_cnt_q <= 2'b00;
                    if (core_clock_sel) begin
                        clk_q <= CLK_TO_SLOW;
                    end
                end
                CLK_TO_SLOW: begin
                    if (slow_edge) begin
                        edge_cnt_q <= edge_cnt_q + 2'b01;
                    end
                    if (edge_cnt_q == 2'(SWITCH_EDGES)) begin
                        clk_q <= CLK_SLOW;
                    end
                end
                CLK_SLOW: begin
                    edge_cnt_q <= 2'b00;
                    if (!core_clock_sel) begin
                        clk_q <= CLK_TO_FAST;
                    end
                end
                default: begin
                    if (slow_edge || !slow_osc_on) begin
                        edge_cnt_q <= edge_cnt_q + 2'b01;
                    end
                    if (edge_cnt_q == 2'(SWITCH_EDGES)) begin
                        clk_q <= CLK_FAST;
                    end
                end
            endcase
        end
    end

    assign core_fast_gate = (clk_q == CLK_FAST);
    assign core_slow_gate = (clk_q == CLK_SLOW);

    // ---------------- halt and idle ----------------
    // available in every operating mode; halt only if the option
    // permits it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ps_q <= PS_RUN;
        end else if (ireset_q) begin
            ps_q <= PS_RUN;
        end else begin
            case (ps_q)
                PS_RUN: begin
                    if (halt_req && halt_option_enable) begin
                        ps_q <= PS_HALT;
                    end else if (idle_req) begin
                        ps_q <= PS_IDLE;
                    end
                end
                PS_HALT: begin
                    if (wake_s2_q) begin
                        ps_q <= PS_RUN;
                    end
                end
                PS_IDLE: begin
                    if (wake_s2_q || window_hit) begin
                        ps_q <= PS_RUN;
                    end
                end
                default: ps_q <= PS_RUN;
            endcase
        end
    end

    // power save only gates enables; register state is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_run <= 1'b0;
            periph_run <= 1'b0;
        end else begin
            core_run <= !ireset_q && ps_q == PS_RUN;
            periph_run <= !ireset_q && ps_q != PS_HALT;
        end
    end

endmodule : power_save_clock_mode_control

// ==== sim/power_save_clock_mode_control_asserts.sv ====
// assertions for the power save clock mode controller
// assumes binding to the top module, seeing its ports only
`timescale 1ns/1ps
module power_save_clock_mode_control_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic halt_option_enable,
    input wire logic slow_osc_on,
    input wire logic fast_osc_on,
    input wire logic idle_timer_clock_sel,
    input wire logic core_clock_sel,
    input wire logic [2:0] idle_interval_sel,
    input wire logic core_fast_gate,
    input wire logic core_slow_gate,
    input wire logic core_run,
    input wire logic periph_run,
    input wire logic internal_reset_n
);
    logic [3:0] nib;
    logic wr;
    logic [11:0] low_q;
    assign nib = {slow_osc_on, fast_osc_on, idle_timer_clock_sel,
        core_clock_sel};
    assign wr = hsel && hready && htrans[1] && hwrite && haddr == 12'h000
        && internal_reset_n;
    function automatic logic ok(input logic [3:0] n);
        return n inside {4'h4, 4'hC, 4'hE, 4'hF, 4'hB};
    endfunction : ok
    // cycles spent in the illegal-mode reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_q <= 12'h000;
        end else if (internal_reset_n) begin
            low_q <= 12'h000;
        end else if (low_q != 12'hFFF) begin
            low_q <= low_q + 12'h001;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RST_VAL: assert property ($rose(hresetn) |-> nib == 4'h4
        && idle_interval_sel == 3'h0) else $error("control not reset");
    AST_WR_CTRL: assert property (wr ##1 ok(hwdata[7:4]) |=>
        nib == $past(hwdata[7:4]) && idle_interval_sel == $past(hwdata[2:0]))
        else $error("control write not applied");
    AST_BAD_RST: assert property (wr ##1 !ok(hwdata[7:4]) |=>
        ##[0:2] !internal_reset_n) else $error("no illegal-mode reset");
    AST_PRESET: assert property ($fell(internal_reset_n) |->
        nib == 4'h4 && idle_interval_sel == 3'h0) else $error("no preset");
    AST_LEGAL: assert property (internal_reset_n |-> ok(nib))
        else $error("illegal mode shown");
    AST_RST_LEN: assert property ($rose(internal_reset_n) |->
        low_q >= 12'd1195 && low_q <= 12'd1290) else $error("reset length");
    AST_RST_STOP: assert property (!internal_reset_n [*2] |->
        !periph_run && !core_run) else $error("running in internal reset");
    AST_GATES: assert property (
        !(core_fast_gate && core_slow_gate)) else $error("both gates open");
    AST_GATE_CLOSE: assert property ($changed(core_clock_sel) |->
        ##[0:2] !(core_clock_sel ? core_fast_gate : core_slow_gate))
        else $error("old gate not closed");
    AST_HALT_OPT: assert property ((!halt_option_enable
        && internal_reset_n) [*4] |-> periph_run) else $error("halted");
endmodule : power_save_clock_mode_control_asserts

bind power_save_clock_mode_control power_save_clock_mode_control_asserts u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .halt_option_enable(halt_option_enable), .slow_osc_on(slow_osc_on),
    .fast_osc_on(fast_osc_on), .idle_timer_clock_sel(idle_timer_clock_sel),
    .core_clock_sel(core_clock_sel), .idle_interval_sel(idle_interval_sel),
    .core_fast_gate(core_fast_gate), .core_slow_gate(core_slow_gate),
    .core_run(core_run), .periph_run(periph_run),
    .internal_reset_n(internal_reset_n)
);

// ==== sim/tb_top.sv ====
// self-checking bench for the power save clock mode controller
// assumes zero wait state bus answers and a free running slow pin
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic slow_clk = 1'b0;
    logic wake = 1'b0;
    logic hopt = 1'b0;
    logic hready;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [2:0] isel;
    logic [3:0] nib;
    logic gf, gs, crun, prun, irst_n;
    logic hresp;
    logic wtick;
    int ticks = 0;
    int bad_count = 0;
    int compares = 0;
    int seed = 32'hb9aa;
    int n;
    logic [3:0] walk [9] = '{4'h4, 4'hC, 4'hE, 4'hF, 4'hB, 4'hF, 4'hE,
        4'hC, 4'h4};
    power_save_clock_mode_control uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .slow_osc_clock(slow_clk), .wakeup_pin(wake),
        .halt_option_enable(hopt), .slow_osc_on(nib[3]),
        .fast_osc_on(nib[2]), .idle_timer_clock_sel(nib[1]),
        .core_clock_sel(nib[0]), .idle_interval_sel(isel),
        .core_fast_gate(gf), .core_slow_gate(gs), .core_run(crun),
        .periph_run(prun), .internal_reset_n(irst_n), .idle_window_tick(wtick)
    );
    always #50 hclk = ~hclk;
    // slow oscillator pin is only ever driven as a plain input
    always begin
        repeat (3) @(posedge hclk);
        slow_clk <= ~slow_clk;
    end
    // counts window pulses away from the edge that launches them
    always @(negedge hclk) begin
        if (wtick === 1'b1) begin
            ticks++;
        end
    end
    function automatic logic legal(input logic [3:0] v);
        return v inside {4'h4, 4'hC, 4'hE, 4'hF, 4'hB};
    endfunction : legal
    function automatic logic [1:0] mode(input logic [3:0] v);
        return v[0] ? 2'b10 : {1'b0, v[1]};
    endfunction : mode
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (60000) @(posedge hclk);
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, 12'h000, 0, rd);
        chk(rd, 32'h40);
        chk(hresp, 1'b0);
        bus(0, 12'h00C, 0, rd);
        chk(rd, 32'h0);
        $display("test reset done");
        foreach (walk[i]) begin
            n = $random(seed);
            bus(1, 12'h000, {n[31:8], walk[i], 1'b0, n[2:0]}, rd);
            bus(0, 12'h000, 0, rd);
            chk(rd, {walk[i], 1'b0, n[2:0]});
            chk({nib, isel}, {walk[i], n[2:0]});
            for (int k = 0; k < 100 &&
                {gf, gs} !== {~walk[i][0], walk[i][0]}; k++) begin
                @(negedge hclk);
            end
            chk({gf, gs}, {~walk[i][0], walk[i][0]});
            bus(0, 12'h004, 0, rd);
            chk(rd[1:0], mode(walk[i]));
        end
        $display("test mode walk done");
        for (int v = 0; v < 16; v++) begin
            if (legal(v[3:0])) begin
                bus(1, 12'h000, 32'hC0, rd);
            end
            bus(1, 12'h000, {24'h0, v[3:0], 4'h5}, rd);
            if (legal(v[3:0])) begin
                bus(0, 12'h000, 0, rd);
                chk(rd, {v[3:0], 4'h5});
                if (v[3:0] == 4'hB) begin
                    bus(1, 12'h000, 32'hF0, rd);
                end
                bus(1, 12'h000, 32'hC0, rd);
                bus(1, 12'h000, 32'h40, rd);
            end else begin
                for (int k = 0; k < 5 && irst_n !== 1'b0; k++) @(negedge hclk);
                bus(1, 12'h000, 32'hC0, rd);
                for (n = 4; n < 2000 && irst_n === 1'b0; n++) @(negedge hclk);
                chk(n >= 1195 && n <= 1290, 1);
                bus(0, 12'h000, 0, rd);
                chk(rd, 32'h40);
            end
        end
        $display("test illegal modes done");
        bus(1, 12'h000, 32'h45, rd);
        bus(1, 12'h008, 32'h1, rd);
        repeat (4) @(negedge hclk);
        chk(prun, 1);
        @(posedge hclk);
        hopt <= 1'b1;
        bus(1, 12'h008, 32'h1, rd);
        repeat (4) @(negedge hclk);
        chk({crun, prun}, 0);
        @(posedge hclk);
        wake <= 1'b1;
        for (int k = 0; k < 2000 && prun !== 1'b1; k++) @(negedge hclk);
        chk(prun, 1);
        @(posedge hclk);
        wake <= 1'b0;
        hopt <= 1'b0;
        bus(0, 12'h000, 0, rd);
        chk(rd, 32'h45);
        $display("test halt done");
        bus(1, 12'h000, 32'h40, rd);
        bus(1, 12'h008, 32'h2, rd);
        repeat (4) @(negedge hclk);
        chk({crun, prun}, 2'b01);
        bus(0, 12'h004, 0, rd);
        chk(rd[3:2], 2'b10);
        ticks = 0;
        for (n = 0; n < 30000 && crun !== 1'b1; n++) @(negedge hclk);
        chk(n < 20500, 1);
        chk(ticks, 1);
        bus(0, 12'h004, 0, rd);
        chk(rd[4:2], 3'b100);
        bus(1, 12'h004, 32'h10, rd);
        bus(0, 12'h004, 0, rd);
        chk(rd[4], 1'b0);
        $display("test idle done");
        end_sim();
    end
endmodule : tb_top
